// *** rrcc_checker.sv ***
/*
 Receive-side RMAP CRC checker with APB register access.
 Assumes the packet receiver delivers bytes and end markers on core_clk
 with the path address already stripped, and a zero-wait APB master.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rrcc_defs.svh"
module rrcc_checker
    import rrcc_pkg::*;
#(
    parameter int LEN_W      = 24,
    parameter bit TX_CRC_CAP = 1'b0
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxData,
    input  wire logic        rxEop,
    input  wire logic        rxEep,
    output logic             rxReady,
    output logic             storeValid,
    output logic      [7:0]  storeData,
    output logic             pktDone
);
    localparam logic [LEN_W-1:0] PID_POS = LEN_W'(`RRCC_PID_POS);
    localparam logic [LEN_W-1:0] INS_POS = LEN_W'(`RRCC_INS_POS);

    rrcc_stream_if #(.W(10)) inBus ();
    rrcc_stream_if #(.W(10)) outBus ();

    rrcc_state_type   state_q;
    logic             descAvail_q;
    logic [LEN_W-1:0] maxLen_q;
    logic [LEN_W-1:0] pos_q;
    logic [LEN_W-1:0] dlen_q;
    logic [7:0]       pid_q;
    logic [7:0]       instr_q;
    logic [7:0]       hdrRx_q;
    logic [7:0]       dataRx_q;
    logic             hdrSeen_q;
    logic             dataSeen_q;
    logic             dataExtra_q;
    logic             ovfRun_q;
    logic             done_q;
    logic             rmap_q;
    logic             withData_q;
    logic             hdrErr_q;
    logic             dataErr_q;
    logic             hdrMatch_q;
    logic             dataMatch_q;
    logic             ovf_q;
    logic             eep_q;
    logic             busy_q;
    logic [7:0]       hdrCrcOut_q;
    logic [7:0]       dataCrcOut_q;
    logic [LEN_W-1:0] len_q;
    logic [31:0]      prdata_q;
    logic             storeValid_q;
    logic [7:0]       storeData_q;
    logic             pktDone_q;

    logic [7:0]       headByte;
    logic             isMark;
    logic             pop;
    logic             byteIn;
    logic             markIn;
    logic             start;
    logic             busyHit;
    logic             withDataC;
    logic [LEN_W-1:0] hIdx;
    logic [LEN_W-1:0] dCnt;
    logic             hdrPhase;
    logic             inData;
    logic [7:0]       hdrCrc;
    logic [7:0]       dataCrc;
    logic             wrEn;
    logic             mapped;
    logic [31:0]      rdMux;
    logic [31:0]      statusWord;

    // Instruction decode: does this packet type carry data
    function automatic logic hasData(input logic [7:0] ins);
        return !ins[7] && ((ins[5:2] == 4'b0111) || (ins[6] ? ins[5] : !ins[5]));
    endfunction

    // Index of the header CRC byte for a given instruction
    function automatic logic [LEN_W-1:0] crcIndex(input logic [7:0] ins);
        if (ins[6]) begin
            return LEN_W'(`RRCC_CMD_CRC_BASE) + LEN_W'({ins[1:0], 2'b00});
        end
        return hasData(ins) ? LEN_W'(`RRCC_RRD_CRC_IDX) : LEN_W'(`RRCC_RWR_CRC_IDX);
    endfunction

    // Receive path buffering, back-pressure reaches the receiver
    assign inBus.valid  = rxValid;
    assign inBus.data   = {rxEep, rxEop, rxData};
    assign rxReady      = inBus.ready;
    assign outBus.ready = (state_q != S_IDLE);

    rrcc_fifo #(.WIDTH(10), .DEPTH(4)) uFifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .inS      (inBus),
        .outS     (outBus)
    );

    // Byte classification at the FIFO head
    assign headByte  = outBus.data[7:0];
    assign isMark    = outBus.data[8] | outBus.data[9];
    assign pop       = outBus.valid & outBus.ready;
    assign byteIn    = (state_q == S_RECV) && pop && !isMark;
    assign markIn    = (state_q == S_RECV) && pop && isMark;
    assign start     = (state_q == S_IDLE) && outBus.valid && descAvail_q;
    assign busyHit   = (state_q == S_IDLE) && outBus.valid && !descAvail_q;
    assign withDataC = hasData(instr_q);
    assign hIdx      = crcIndex(instr_q);
    assign dCnt      = pos_q - hIdx - LEN_W'(1);
    assign hdrPhase  = (pos_q <= INS_POS) || (pos_q < hIdx);
    assign inData    = withDataC && (pos_q > INS_POS) && (pos_q > hIdx);

    // Header and data CRC engines, updated as bytes arrive
    rrcc_crc_unit uHdrCrc (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clear    (start),
        .update   (byteIn && hdrPhase),
        .dataIn   (headByte),
        .crc      (hdrCrc)
    );

    rrcc_crc_unit uDataCrc (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clear    (start),
        .update   (byteIn && inData && (dCnt < dlen_q)),
        .dataIn   (headByte),
        .crc      (dataCrc)
    );

    // Sequencer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (start) begin
                        state_q <= S_RECV;
                    end else if (busyHit) begin
                        state_q <= S_DROP;
                    end
                end
                S_RECV: begin
                    if (markIn) begin
                        state_q <= S_IDLE;
                    end
                end
                S_DROP: begin
                    if (pop && isMark) begin
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Packet parsing while receiving
    always_ff @(posedge core_clk) begin
        if (!rst_n || start) begin
            pos_q       <= '0;
            dlen_q      <= '0;
            pid_q       <= '0;
            instr_q     <= '0;
            hdrRx_q     <= '0;
            dataRx_q    <= '0;
            hdrSeen_q   <= 1'b0;
            dataSeen_q  <= 1'b0;
            dataExtra_q <= 1'b0;
            ovfRun_q    <= 1'b0;
        end else if (byteIn) begin
            pos_q <= pos_q + LEN_W'(1);
            if (pos_q == PID_POS) begin
                pid_q <= headByte;
            end
            if (pos_q == INS_POS) begin
                instr_q <= headByte;
            end
            if (pos_q > INS_POS && pos_q == hIdx) begin
                hdrRx_q   <= headByte;
                hdrSeen_q <= 1'b1;
            end
            if (withDataC && pos_q > INS_POS && pos_q < hIdx
                    && pos_q >= hIdx - LEN_W'(`RRCC_LEN_BYTES)) begin
                dlen_q <= {dlen_q[LEN_W-9:0], headByte};
            end
            if (inData && dCnt == dlen_q) begin
                dataRx_q   <= headByte;
                dataSeen_q <= 1'b1;
            end
            if (inData && dCnt > dlen_q) begin
                dataExtra_q <= 1'b1;
            end
            if (pos_q >= maxLen_q) begin
                ovfRun_q <= 1'b1;
            end
        end
    end

    // Store strobe, never beyond the byte limit
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            storeValid_q <= 1'b0;
            storeData_q  <= '0;
        end else begin
            storeValid_q <= byteIn && (pos_q < maxLen_q);
            storeData_q  <= headByte;
        end
    end

    // Results latched only at the end marker
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rmap_q       <= 1'b0;
            withData_q   <= 1'b0;
            hdrErr_q     <= 1'b0;
            dataErr_q    <= 1'b0;
            hdrMatch_q   <= 1'b0;
            dataMatch_q  <= 1'b0;
            ovf_q        <= 1'b0;
            eep_q        <= 1'b0;
            hdrCrcOut_q  <= '0;
            dataCrcOut_q <= '0;
            len_q        <= '0;
            pktDone_q    <= 1'b0;
        end else begin
            pktDone_q <= markIn;
            if (markIn) begin
                rmap_q       <= (pos_q > PID_POS) && (pid_q == `RRCC_RMAP_PID);
                withData_q   <= (pos_q > INS_POS) && withDataC;
                hdrErr_q     <= !hdrSeen_q || instr_q[7];
                dataErr_q    <= !dataSeen_q || dataExtra_q;
                hdrMatch_q   <= (hdrCrc == hdrRx_q);
                dataMatch_q  <= (dataCrc == dataRx_q);
                hdrCrcOut_q  <= hdrCrc;
                dataCrcOut_q <= dataCrc;
                ovf_q        <= ovfRun_q;
                eep_q        <= outBus.data[9];
                len_q        <= (ovfRun_q || outBus.data[9]) ? '0 : pos_q;
            end
        end
    end

    // APB decode
    assign wrEn   = psel && penable && pwrite;
    assign mapped = (paddr == `RRCC_OFF_CTRL) || (paddr == `RRCC_OFF_MAXLEN)
                 || (paddr == `RRCC_OFF_STATUS) || (paddr == `RRCC_OFF_CRC)
                 || (paddr == `RRCC_OFF_LEN) || (paddr == `RRCC_OFF_CAPS);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Descriptor, done and busy flags; set wins over clear (arm write for descriptor, hardware for done and busy)
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            descAvail_q <= 1'b0;
            done_q      <= 1'b0;
            busy_q      <= 1'b0;
            maxLen_q    <= LEN_W'(`RRCC_MAXLEN_RST);
        end else begin
            if (wrEn && paddr == `RRCC_OFF_CTRL && pwdata[`RRCC_CTRL_ARM]) begin
                descAvail_q <= 1'b1;
            end else if (markIn) begin
                descAvail_q <= 1'b0;
            end
            if (markIn) begin
                done_q <= 1'b1;
            end else if (wrEn && ((paddr == `RRCC_OFF_STATUS && pwdata[`RRCC_ST_DONE])
                    || (paddr == `RRCC_OFF_CTRL && pwdata[`RRCC_CTRL_ARM]))) begin
                done_q <= 1'b0;
            end
            if (busyHit) begin
                busy_q <= 1'b1;
            end else if (wrEn && paddr == `RRCC_OFF_STATUS && pwdata[`RRCC_ST_BUSY]) begin
                busy_q <= 1'b0;
            end
            if (wrEn && paddr == `RRCC_OFF_MAXLEN) begin
                maxLen_q <= pwdata[LEN_W-1:0];
            end
        end
    end

    // Read mux
    assign statusWord = {22'h00_0000, busy_q, eep_q, ovf_q, dataMatch_q, hdrMatch_q,
                         dataErr_q, hdrErr_q, withData_q, rmap_q, done_q};
    always_comb begin
        rdMux = '0;
        case (paddr)
            `RRCC_OFF_CTRL:   rdMux = {31'h0000_0000, descAvail_q};
            `RRCC_OFF_MAXLEN: rdMux = 32'(maxLen_q);
            `RRCC_OFF_STATUS: rdMux = statusWord;
            `RRCC_OFF_CRC:    rdMux = {16'h0000, dataCrcOut_q, hdrCrcOut_q};
            `RRCC_OFF_LEN:    rdMux = 32'(len_q);
            `RRCC_OFF_CAPS:   rdMux = {30'h0000_0000, TX_CRC_CAP, 1'b1};
            default:          rdMux = '0;
        endcase
    end

    // Read data captured in the setup cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata_q <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rdMux;
        end
    end

    assign prdata     = prdata_q;
    assign storeValid = storeValid_q;
    assign storeData  = storeData_q;
    assign pktDone    = pktDone_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_DONE_AFTER_END: assert property ($rose(done_q) |-> $past(markIn))
        else $error("results shown without end marker");
    AST_PROTO_FLAG: assert property (markIn && pos_q > PID_POS |=>
        rmap_q == ($past(pid_q) == 8'h01)) else $error("protocol flag wrong");
    AST_STORE_LIMIT: assert property (storeValid |-> $past(pos_q) < $past(maxLen_q))
        else $error("stored beyond limit");
    AST_LEN_GOOD: assert property (markIn && !ovfRun_q && !outBus.data[9] |=>
        len_q == $past(pos_q)) else $error("length not byte count");
    AST_OVF_EMPTY: assert property (markIn && ovfRun_q |=> ovf_q && len_q == '0)
        else $error("overflow delivered data");
    AST_EEP_EMPTY: assert property (markIn && outBus.data[9] |=> eep_q && len_q == '0)
        else $error("eep packet delivered data");
    AST_CAPS: assert property (psel && !penable && !pwrite && paddr == `RRCC_OFF_CAPS
        |=> prdata[1:0] == {TX_CRC_CAP, 1'b1}) else $error("capability bits wrong");
    AST_BUSY: assert property (busyHit |=> busy_q && state_q == S_DROP ##1 !storeValid)
        else $error("packet taken without descriptor");
    AST_HDR_MATCH: assert property (markIn |=> hdrMatch_q == (hdrCrcOut_q == $past(hdrRx_q)))
        else $error("header match wrong");
    AST_DATA_MATCH: assert property (markIn |=> dataMatch_q == (dataCrcOut_q == $past(dataRx_q)))
        else $error("data match wrong");

    COV_GOOD: cover property (markIn && hdrSeen_q && !ovfRun_q);
    COV_BUSY: cover property (busyHit);
    COV_OVF:  cover property (markIn && ovfRun_q);
endmodule // rrcc_checker
`default_nettype wire

// *** rrcc_defs.svh ***
/*
 Constants of the receive-side RMAP CRC checker: register offsets, field
 positions, reset values and packet layout figures.
 Assumes inclusion by bare name; holds definitions only.
*/
// Notes on behaviour
// - CRCs run while bytes arrive; results appear only after the end marker.
// - Protocol flag set when protocol identifier byte says RMAP.
// - With protocol flag clear, all other results are meaningless.
// - With-data flag from instruction; when clear, data results are meaningless.
// - Header error flag on malformed header; then header match and CRC meaningless.
// - Data error flag on malformed data part; then data match and CRC meaningless.
// - Computed header CRC shown; match flag when equal to received header CRC.
// - Computed data CRC shown; match flag when equal to received data CRC.
// - Software sets byte limit; never more bytes stored than that.
// - Good packet reports number of bytes stored.
// - Packet longer than limit flags overflow and reports no data.
// - Packet ended by error marker flagged incomplete, reports no data.
// - Two read-only capability bits: receive and transmit hardware CRC.
// - Packet arriving without posted descriptor is refused and busy flagged.
`ifndef RRCC_DEFS_SVH
`define RRCC_DEFS_SVH
`define RRCC_OFF_CTRL     12'h000
`define RRCC_OFF_MAXLEN   12'h004
`define RRCC_OFF_STATUS   12'h008
`define RRCC_OFF_CRC      12'h00C
`define RRCC_OFF_LEN      12'h010
`define RRCC_OFF_CAPS     12'h014
`define RRCC_CTRL_ARM     0
`define RRCC_ST_DONE      0
`define RRCC_ST_BUSY      9
`define RRCC_MAXLEN_RST   24'h00_0400
`define RRCC_CRC_INIT     8'h00
`define RRCC_CRC_POLY     8'hE0
`define RRCC_RMAP_PID     8'h01
`define RRCC_PID_POS      1
`define RRCC_INS_POS      2
`define RRCC_CMD_CRC_BASE 15
`define RRCC_RRD_CRC_IDX  11
`define RRCC_RWR_CRC_IDX  7
`define RRCC_LEN_BYTES    3
`endif

// *** rrcc_pkg.sv ***
/*
 Types and the CRC step shared by the checker modules.
 Assumes the constants header is on the include path.
*/
`default_nettype none
package rrcc_pkg;
    `include "rrcc_defs.svh"

    // Receive sequencer states
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_RECV = 3'b010,
        S_DROP = 3'b100
    } rrcc_state_type;

    // One byte of RMAP CRC-8, reflected form
    function automatic logic [7:0] rrccCrcStep(input logic [7:0] crc, input logic [7:0] din);
        logic [7:0] c;
        c = crc ^ din;
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `RRCC_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction
endpackage
`default_nettype wire

// *** rrcc_stream_if.sv ***
/*
 Valid/ready byte stream carrier between checker modules.
 Assumes both ends share one clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface rrcc_stream_if #(parameter int W = 10);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** rrcc_fifo.sv ***
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes interface width equals WIDTH; one clock, synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module rrcc_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    rrcc_stream_if.snk inS,
    rrcc_stream_if.src outS
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // Honest full and empty
    assign inS.ready  = (cnt_q != (AW+1)'(DEPTH));
    assign outS.valid = (cnt_q != '0);
    assign outS.data  = mem_q[rp_q];
    assign push       = inS.valid & inS.ready;
    assign pop        = outS.valid & outS.ready;

    // Storage
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wp_q] <= inS.data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    AST_FIFO_BOUND: assert property (@(posedge core_clk) disable iff (!rst_n)
        cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule // rrcc_fifo
`default_nettype wire

// *** rrcc_crc_unit.sv ***
/*
 Running RMAP CRC-8 register with clear and byte update.
 Assumes clear and update come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rrcc_defs.svh"
module rrcc_crc_unit
    import rrcc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       clear,
    input  wire logic       update,
    input  wire logic [7:0] dataIn,
    output logic      [7:0] crc
);
    logic [7:0] crc_q;

    // Clear wins over a byte in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n || clear) begin
            crc_q <= `RRCC_CRC_INIT;
        end else if (update) begin
            crc_q <= rrccCrcStep(crc_q, dataIn);
        end
    end
    assign crc = crc_q;

    AST_CRC_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
        clear |=> crc == 8'h00 ##1 (crc == $past(crc) || $past(update)))
        else $error("crc not restarted from zero");
endmodule // rrcc_crc_unit
`default_nettype wire

// *** rrcc_rx_model.sv ***
/*
 Packet receiver model: sends the bytes in pkt, then one end marker.
 Assumes send is called just after a rising edge of core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module rrcc_rx_model (
    input  wire logic       core_clk,
    input  wire logic       rxReady,
    output logic            rxValid,
    output logic      [7:0] rxData,
    output logic            rxEop,
    output logic            rxEep
);
    logic [7:0] pkt [0:31];

    // Idle lines at time zero
    initial begin
        rxValid = 1'b0;
        rxData  = 8'h00;
        rxEop   = 1'b0;
        rxEep   = 1'b0;
    end

    // Each beat held until taken; released data shows inverted value
    task automatic send(input int n, input bit eep, input bit slow);
        for (int i = 0; i <= n; i++) begin
            rxValid <= 1'b1;
            rxData  <= (i < n) ? pkt[i] : ~rxData;
            rxEop   <= (i == n) && !eep;
            rxEep   <= (i == n) && eep;
            @(posedge core_clk);
            while (rxReady !== 1'b1) @(posedge core_clk);
            if (slow || i == n) begin
                rxValid <= 1'b0;
                rxEop   <= 1'b0;
                rxEep   <= 1'b0;
                rxData  <= ~rxData;
                if (i < n) @(posedge core_clk);
            end
        end
    endtask
endmodule // rrcc_rx_model
`default_nettype wire

// *** testbench.sv ***
/*
 Self-checking bench for the receive-side RMAP CRC checker.
 Assumes the receiver model and the design files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rrcc_defs.svh"
module testbench;
    logic        core_clk, rst_n, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, rxValid, rxEop, rxEep, rxReady;
    logic        storeValid, pktDone, gotDone;
    logic [7:0]  rxData, storeData;
    int          failures, n_tests, storeCnt, storeBase;

    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    rrcc_checker DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxValid(rxValid), .rxData(rxData), .rxEop(rxEop),
        .rxEep(rxEep), .rxReady(rxReady), .storeValid(storeValid),
        .storeData(storeData), .pktDone(pktDone));
    rrcc_rx_model rx (.core_clk(core_clk), .rxReady(rxReady), .rxValid(rxValid),
        .rxData(rxData), .rxEop(rxEop), .rxEep(rxEep));

    // Count stored bytes, each held against the packet image
    always @(posedge core_clk) begin
        if (storeValid === 1'b1) begin
            chk("store data", storeData, rx.pkt[storeCnt - storeBase]);
            storeCnt <= storeCnt + 1;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; read data and error taken at the pready edge
    task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        err = pslverr;
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reference CRC, reflected, over pkt[s..s+n-1]
    function automatic logic [7:0] crc8(input int s, input int n);
        logic [7:0] c;
        c = `RRCC_CRC_INIT;
        for (int i = s; i < s + n; i++) begin
            c = c ^ rx.pkt[i];
            for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ `RRCC_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // Header with data length, then data and data CRC
    task automatic mk(input logic [7:0] pid, input logic [7:0] ins, input int dlen);
        for (int i = 0; i < 32; i++) rx.pkt[i] = 8'(i * 7);
        rx.pkt[1] = pid;
        rx.pkt[2] = ins;
        rx.pkt[12] = 8'h00;
        rx.pkt[13] = 8'h00;
        rx.pkt[14] = 8'(dlen);
        rx.pkt[15] = crc8(0, 15);
        rx.pkt[16 + dlen] = crc8(16, dlen);
    endtask

    // Send n bytes and a marker, wait for the end pulse
    task automatic run(input int n, input bit eep, input bit arm, output int stored);
        if (arm) apb(1'b1, `RRCC_OFF_CTRL, 32'h0000_0001);
        storeBase = storeCnt;
        @(posedge core_clk);
        rx.send(n, eep, n[0]);
        for (int k = 0; k < 60 && pktDone !== 1'b1; k++) @(negedge core_clk);
        gotDone = pktDone;
        stored  = storeCnt - storeBase;
    endtask

    task automatic tRegs();
        apb(1'b1, `RRCC_OFF_CAPS, 32'hFFFF_FFFF);
        apb(1'b0, `RRCC_OFF_CAPS, '0);
        chk("caps", rd, 32'h0000_0001);
        apb(1'b0, `RRCC_OFF_MAXLEN, '0);
        chk("limit reset", rd, 32'h0000_0400);
        apb(1'b0, 12'h020, '0);
        chk("unmapped", err, 1'b1);
    endtask

    task automatic tGood();
        int s;
        mk(8'h01, 8'h6C, 4);
        apb(1'b1, `RRCC_OFF_CTRL, 32'h0000_0001);
        apb(1'b0, `RRCC_OFF_STATUS, '0);
        chk("done early", rd[0], 1'b0);
        run(21, 1'b0, 1'b0, s);
        chk("stored", s, 21);
        chk("end pulse", gotDone, 1'b1);
        apb(1'b0, `RRCC_OFF_STATUS, '0);
        chk("status", rd, 32'h0000_0067);
        apb(1'b0, `RRCC_OFF_CRC, '0);
        chk("crcs", rd, {16'h0000, rx.pkt[20], rx.pkt[15]});
        apb(1'b0, `RRCC_OFF_LEN, '0);
        chk("len", rd, 21);
    endtask

    // Header mismatch, data error, short header, other protocol
    task automatic tErr();
        int s;
        mk(8'h01, 8'h4C, 0);
        rx.pkt[15] = ~rx.pkt[15];
        run(16, 1'b0, 1'b1, s);
        apb(1'b0, `RRCC_OFF_STATUS, '0);
        chk("hdr miss", rd & 32'h0000_002F, 32'h0000_0003);
        apb(1'b0, `RRCC_OFF_CRC, '0);
        chk("hdr crc", rd[7:0], 8'(~rx.pkt[15]));
        mk(8'h01, 8'h6C, 2);
        run(20, 1'b0, 1'b1, s);
        apb(1'b0, `RRCC_OFF_STATUS, '0);
        chk("data err", rd & 32'h0000_003F, 32'h0000_0037);
        run(6, 1'b0, 1'b1, s);
        apb(1'b0, `RRCC_OFF_STATUS, '0);
        chk("hdr err", rd & 32'h0000_000B, 32'h0000_000B);
        mk(8'h02, 8'h4C, 0);
        run(16, 1'b0, 1'b1, s);
        chk("other stored", s, 16);
        apb(1'b0, `RRCC_OFF_STATUS, '0);
        chk("other", rd & 32'h0000_0003, 32'h0000_0001);
    endtask

    // Limit one below and equal to the packet length
    task automatic tLimit();
        int s;
        mk(8'h01, 8'h6C, 4);
        for (int lim = 20; lim < 22; lim++) begin
            apb(1'b1, `RRCC_OFF_MAXLEN, lim);
            run(21, 1'b0, 1'b1, s);
            chk("limit stored", s, lim);
            apb(1'b0, `RRCC_OFF_STATUS, '0);
            chk("overflow", rd[7], lim == 20);
            apb(1'b0, `RRCC_OFF_LEN, '0);
            chk("limit len", rd, (lim == 20) ? 0 : 21);
        end
        apb(1'b1, `RRCC_OFF_MAXLEN, 32'h0000_0400);
        run(21, 1'b1, 1'b1, s);
        apb(1'b0, `RRCC_OFF_STATUS, '0);
        chk("eep", rd[8], 1'b1);
        apb(1'b0, `RRCC_OFF_LEN, '0);
        chk("eep len", rd, 0);
    endtask

    // No descriptor posted: refused, busy until cleared
    task automatic tBusy();
        int s;
        apb(1'b1, `RRCC_OFF_STATUS, 32'h0000_0001);
        run(21, 1'b0, 1'b0, s);
        chk("busy stored", s, 0);
        chk("busy end pulse", gotDone, 1'b0);
        apb(1'b0, `RRCC_OFF_STATUS, '0);
        chk("busy", rd & 32'h0000_0201, 32'h0000_0200);
        apb(1'b1, `RRCC_OFF_STATUS, 32'h0000_0200);
        apb(1'b0, `RRCC_OFF_STATUS, '0);
        chk("busy clr", rd[9], 1'b0);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Reset, then scenarios
    initial begin
        rst_n   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        tRegs();
        tGood();
        tErr();
        tLimit();
        tBusy();
        test_done();
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        test_done();
    end
endmodule // testbench
`default_nettype wire
